// >>> rtl/eib_map.svh
// offsets, field positions, reset values and limits of the input image builder
`ifndef EIB_MAP_SVH
`define EIB_MAP_SVH

`define EIB_ADDR_CTRL     8'h00
`define EIB_ADDR_WDATA    8'h04
`define EIB_ADDR_IMG_HI   8'h08
`define EIB_ADDR_IMG_LO   8'h0C

`define EIB_CTRL_RD_LSB   0
`define EIB_CTRL_WR_LSB   8
`define EIB_CTRL_WR_REQ   16
`define EIB_CTRL_EN_A     17
`define EIB_CTRL_CLR_A    18
`define EIB_CTRL_EN_B     19
`define EIB_CTRL_CLR_B    20
`define EIB_CTRL_STOP     24
`define EIB_CTRL_RST      32'h00000000

`define EIB_IMG_BYTES     8
`define EIB_LAST_INDEX    6'h1F
`define EIB_IDX_POS       6'h00
`define EIB_IDX_CMP_A     6'h01
`define EIB_IDX_CMP_B     6'h02
`define EIB_IDX_LOWER     6'h03
`define EIB_IDX_UPPER     6'h04
`define EIB_IDX_STS_EN    6'h05

`define EIB_LOWER_RST     32'h00000000
`define EIB_UPPER_RST     32'hFFFFFFFF
`define EIB_STS_EN_RST    4'hF

`endif

// >>> rtl/eib_pkg.sv
// types shared by the input image builder
package eib_pkg;
  typedef logic [31:0] eib_word_t;
  typedef logic [5:0]  eib_index_t;
  typedef logic [63:0] eib_image_t;
  typedef enum logic {EIB_WR_IDLE, EIB_WR_BUSY} eib_wr_state_t;
endpackage

// >>> rtl/eib_bank.sv
// register bank storage, 64 words, registered read data
`timescale 1ns/1ns
module eib_bank
  import eib_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      wr_en,
  input  wire eib_index_t wr_idx,
  input  wire eib_word_t wr_data,
  input  wire eib_index_t rd_idx,
  output eib_word_t      rd_data
);
  eib_word_t mem [0:63];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // storage itself is not reset; only the read register is
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule // eib_bank

// >>> rtl/eib_top.sv
// encoder input image builder with apb access
//
// Behaviour
// [R1] input image is exactly eight bytes
// [R2] bytes 0-3 read result, msb first
// [R3] accepted read clears reject, returns content
// [R4] rejected read sets flag, zero data
// [R5] byte 4: reject bit 7, index 5:0
// [R6] write_done shows write success or failure
// [R7] pending low when no request, idle
// [R8] request starts write, pending high, refuse more
// [R9] byte 5: done, pending, encoder status
// [R10] encoder status bits passed into byte 5
// [R11] up/down only while values change
// [R12] status and error bits are live
// [R13] flags latch until explicitly cleared
// [R14] byte 6 direction and comparator b bits
// [R15] byte 7 diagnostics layout
// [R16] byte 6 bits 1,0 comparator a
// [R17] match latches flag, clear bit clears
// [R18] parameter error halts encoder link
// [R19] halted while stop or parameter error
// [R20] summary set by any enabled status
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "eib_map.svh"
module eib_top
  import eib_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        POS_VALID,
  input  wire logic [31:0] POS_VALUE,
  input  wire logic [3:0]  ENCODER_STATUS,
  input  wire logic        ENCODER_SIGNAL_FAULT,
  input  wire logic        PARAMETER_ERROR,
  output logic             LINK_HALTED,
  output logic [63:0]      INPUT_IMAGE
);
  function automatic logic index_ok(input eib_index_t idx, input logic allow_pos);
    index_ok = (idx <= `EIB_LAST_INDEX) && (allow_pos || (idx != `EIB_IDX_POS));
  endfunction

  eib_word_t     ctrl;
  eib_word_t     wdata;
  eib_word_t     pos;
  eib_word_t     cmp_a;
  eib_word_t     cmp_b;
  eib_word_t     lower;
  eib_word_t     upper;
  logic [3:0]    sts_en;
  eib_word_t     bank_rdata;
  eib_index_t    idx_q;
  eib_image_t    img;
  eib_wr_state_t wr_state;
  eib_wr_state_t next_wr_state;
  logic          write_done;
  logic          counting_up;
  logic          counting_down;
  logic          cmp_a_match_latched;
  logic          cmp_b_match_latched;

  // apb decode
  wire logic       apb_acc     = PSEL && PENABLE;
  wire logic       hit_ctrl    = (PADDR == `EIB_ADDR_CTRL);
  wire logic       hit_wdata   = (PADDR == `EIB_ADDR_WDATA);
  wire logic       hit_img_hi  = (PADDR == `EIB_ADDR_IMG_HI);
  wire logic       hit_img_lo  = (PADDR == `EIB_ADDR_IMG_LO);
  wire logic       hit_any     = hit_ctrl || hit_wdata || hit_img_hi || hit_img_lo;
  wire logic       wr_ctrl     = apb_acc && PWRITE && hit_ctrl;
  wire logic       wr_wdata    = apb_acc && PWRITE && hit_wdata;

  // fields of the control word
  wire eib_index_t rd_index    = ctrl[`EIB_CTRL_RD_LSB +: 6];
  wire eib_index_t wr_index    = ctrl[`EIB_CTRL_WR_LSB +: 6];
  wire logic       wr_req      = ctrl[`EIB_CTRL_WR_REQ];
  wire logic       en_a        = ctrl[`EIB_CTRL_EN_A];
  wire logic       clr_a       = ctrl[`EIB_CTRL_CLR_A];
  wire logic       en_b        = ctrl[`EIB_CTRL_EN_B];
  wire logic       clr_b       = ctrl[`EIB_CTRL_CLR_B];
  wire logic       stop        = ctrl[`EIB_CTRL_STOP];

  // write handshake
  wire logic       write_pending = (wr_state == EIB_WR_BUSY);
  wire logic       wr_go         = wr_req && !write_pending; // R8
  wire logic       wr_ok         = index_ok(wr_index, 1'b0);
  wire logic       bank_we       = wr_go && wr_ok;

  // read path, index follows bank read latency
  wire logic       rd_reject   = !index_ok(idx_q, 1'b1);
  wire eib_word_t  rd_value    = (idx_q == `EIB_IDX_POS) ? pos : bank_rdata;
  wire eib_word_t  rd_result   = rd_reject ? 32'h00000000 : rd_value; // R3 R4

  // live comparisons on the latest position
  wire logic       cmp_a_match_live = en_a && (pos == cmp_a);
  wire logic       cmp_b_match_live = en_b && (pos == cmp_b);
  wire logic       cmp_a_relation   = (pos >= cmp_a);
  wire logic       cmp_b_relation   = (pos >= cmp_b);
  wire logic       below_lower_limit = (pos < lower); // R12
  wire logic       above_upper_limit = (pos > upper); // R12
  wire logic       summary_diagnostic = |(ENCODER_STATUS & sts_en); // R20
  wire logic       link_halted = stop || PARAMETER_ERROR; // R18 R19

  wire eib_image_t next_img = {
    rd_result,                                                        // R2
    rd_reject, 1'b0, idx_q,                                           // R5
    write_done, write_pending, 2'b00, ENCODER_STATUS,                 // R9 R10
    counting_up, counting_down, cmp_b_relation, cmp_b_match_latched,  // R14
    cmp_b_match_live, cmp_a_relation, cmp_a_match_latched, cmp_a_match_live, // R16
    link_halted, 2'b00, PARAMETER_ERROR, below_lower_limit,           // R15
    above_upper_limit, ENCODER_SIGNAL_FAULT, summary_diagnostic
  };

  eib_bank u_bank (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .wr_en   (bank_we),
    .wr_idx  (wr_index),
    .wr_data (wdata),
    .rd_idx  (rd_index),
    .rd_data (bank_rdata)
  );

  assign PREADY      = 1'b1;
  assign PSLVERR     = apb_acc && !hit_any;
  assign LINK_HALTED = link_halted;
  assign INPUT_IMAGE = img; // R1

  always_comb begin
    PRDATA = 32'h00000000;
    if (hit_ctrl) begin
      PRDATA = ctrl;
    end else if (hit_wdata) begin
      PRDATA = wdata;
    end else if (hit_img_hi) begin
      PRDATA = img[63:32];
    end else if (hit_img_lo) begin
      PRDATA = img[31:0];
    end
  end

  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      EIB_WR_IDLE: if (wr_req) next_wr_state = EIB_WR_BUSY; // R8
      EIB_WR_BUSY: if (!wr_req) next_wr_state = EIB_WR_IDLE; // R7
      default:     next_wr_state = EIB_WR_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl  <= `EIB_CTRL_RST;
      wdata <= 32'h00000000;
    end else begin
      if (wr_ctrl) ctrl <= PWDATA;
      if (wr_wdata) wdata <= PWDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_state   <= EIB_WR_IDLE;
      write_done <= 1'b0;
      idx_q      <= 6'h00;
      img        <= 64'h0000000000000000;
    end else begin
      wr_state <= next_wr_state;
      if (wr_go) write_done <= wr_ok; // R6
      idx_q <= rd_index;
      img   <= next_img;
    end
  end

  // shadows of bank words the comparators and the summary mask need every cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cmp_a  <= 32'h00000000;
      cmp_b  <= 32'h00000000;
      lower  <= `EIB_LOWER_RST;
      upper  <= `EIB_UPPER_RST;
      sts_en <= `EIB_STS_EN_RST;
    end else if (bank_we) begin
      if (wr_index == `EIB_IDX_CMP_A) cmp_a <= wdata;
      if (wr_index == `EIB_IDX_CMP_B) cmp_b <= wdata;
      if (wr_index == `EIB_IDX_LOWER) lower <= wdata;
      if (wr_index == `EIB_IDX_UPPER) upper <= wdata;
      if (wr_index == `EIB_IDX_STS_EN) sts_en <= wdata[3:0];
    end
  end

  // position and direction; frozen while the link is halted
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pos           <= 32'h00000000;
      counting_up   <= 1'b0;
      counting_down <= 1'b0;
    end else if (POS_VALID && !link_halted) begin
      pos           <= POS_VALUE;
      counting_up   <= (POS_VALUE > pos); // R11
      counting_down <= (POS_VALUE < pos); // R11
    end
  end

  // set wins over clear so a match in the clear cycle survives
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cmp_a_match_latched <= 1'b0;
      cmp_b_match_latched <= 1'b0;
    end else begin
      cmp_a_match_latched <= cmp_a_match_live || (cmp_a_match_latched && !clr_a); // R13 R17
      cmp_b_match_latched <= cmp_b_match_live || (cmp_b_match_latched && !clr_b); // R13 R17
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_read_zero_on_reject: assert property (img[31] |-> img[63:32] == 32'h00000000) // R4
    else $error("rejected read returned data");
  chk_reject_data_zero: assert property (rd_reject |=> img[63:32] == 32'h00000000 && img[31]) // R4
    else $error("rejected read not zero or flag low");
  chk_read_accept_data: assert property (!rd_reject && idx_q != `EIB_IDX_POS |=> !img[31] && img[63:32] == $past(bank_rdata)) // R3
    else $error("accepted read data mismatch");
  chk_index_echo: assert property (##1 img[29:24] == $past(idx_q)) // R5
    else $error("read index not echoed");
  chk_pending_raise: assert property (wr_req && !write_pending |=> write_pending ##1 img[22]) // R8
    else $error("write pending not raised");
  chk_pending_idle: assert property (!wr_req |=> !write_pending) // R7
    else $error("write pending stuck high");
  chk_write_done_value: assert property (wr_go |=> write_done == $past(wr_ok)) // R6
    else $error("write done wrong");
  chk_dir_exclusive: assert property (!(counting_up && counting_down)) // R11
    else $error("both directions set");
  chk_dir_constant: assert property (POS_VALID && !link_halted && POS_VALUE == pos |=> !counting_up && !counting_down) // R11
    else $error("direction set on constant value");
  chk_flag_hold: assert property (cmp_a_match_latched && !clr_a |=> cmp_a_match_latched) // R13
    else $error("comparator flag lost");
  chk_flag_set: assert property (cmp_b_match_live |=> cmp_b_match_latched ##1 img[12]) // R17
    else $error("comparator flag not set");
  chk_halt_freeze: assert property (link_halted |=> $stable(pos)) // R18
    else $error("position moved while halted");
  chk_halt_bit: assert property (##1 img[7] == $past(stop || PARAMETER_ERROR)) // R19
    else $error("halted bit wrong");
  chk_summary_bit: assert property (##1 img[0] == |($past(ENCODER_STATUS) & $past(sts_en))) // R20
    else $error("summary diagnostic wrong");

  cov_write_ok: cover property (wr_go && wr_ok ##1 write_pending ##[1:20] !write_pending);
  cov_read_reject: cover property (rd_reject ##1 img[31]);
  cov_flag_clear: cover property (cmp_a_match_latched ##1 clr_a ##1 !cmp_a_match_latched);
endmodule // eib_top

// >>> sim/eib_enc_model.sv
// encoder stand-in that feeds position pulses
`timescale 1ns/1ns
module eib_enc_model
  import eib_pkg::*;
(
  input  wire logic clk,
  input  wire logic halted,
  output logic      pos_valid,
  output eib_word_t pos_value
);
  initial begin
    pos_valid = 1'b0;
    pos_value = 32'h0;
  end
  task automatic put(input eib_word_t v);
    if (halted !== 1'b1) begin
      @(posedge clk);
      pos_valid <= 1'b1;
      pos_value <= v;
      @(posedge clk);
      pos_valid <= 1'b0;
      pos_value <= ~v; // stale value must not look valid
    end
  endtask
endmodule // eib_enc_model

// >>> sim/tb_top.sv
// self-checking bench for the input image builder
`timescale 1ns/1ns
`include "eib_map.svh"
module tb_top
  import eib_pkg::*;
;
  logic       CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, POS_VALID;
  logic [7:0] PADDR;
  eib_word_t  PWDATA, PRDATA, POS_VALUE, ctl, rd;
  logic [3:0] ENCODER_STATUS;
  logic       ENCODER_SIGNAL_FAULT, PARAMETER_ERROR, LINK_HALTED, er;
  eib_image_t INPUT_IMAGE;
  int         n_errors, checked, cyc;

  eib_top uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POS_VALID(POS_VALID), .POS_VALUE(POS_VALUE), .ENCODER_STATUS(ENCODER_STATUS),
    .ENCODER_SIGNAL_FAULT(ENCODER_SIGNAL_FAULT), .PARAMETER_ERROR(PARAMETER_ERROR),
    .LINK_HALTED(LINK_HALTED), .INPUT_IMAGE(INPUT_IMAGE));
  eib_enc_model enc (.clk(CORE_CLK), .halted(LINK_HALTED), .pos_valid(POS_VALID), .pos_value(POS_VALUE));

  always #5 CORE_CLK = ~CORE_CLK;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; waits for pready, takes answer at that edge
  task automatic apb(input logic w, input logic [7:0] a, input eib_word_t d);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CORE_CLK);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge CORE_CLK);
  endtask

  task automatic wt_pending(input logic v);
    int n;
    n = 0;
    while (INPUT_IMAGE[22] !== v && n < 20) begin
      @(posedge CORE_CLK);
      n++;
    end
    chk("write_pending", v, INPUT_IMAGE[22]);
  endtask

  // full handshake: request, wait pending, drop request, wait idle
  task automatic bank_wr(input eib_index_t idx, input eib_word_t v);
    apb(1'b1, `EIB_ADDR_WDATA, v);
    apb(1'b1, `EIB_ADDR_CTRL, ctl | (32'(idx) << 8) | 32'h00010000);
    wt_pending(1'b1);
    apb(1'b1, `EIB_ADDR_CTRL, ctl);
    wt_pending(1'b0);
  endtask

  task automatic put_ctl(input eib_word_t v);
    ctl = v;
    apb(1'b1, `EIB_ADDR_CTRL, ctl);
    settle();
  endtask

  task automatic pins(input logic [3:0] s, input logic f, input logic p);
    ENCODER_STATUS <= s;
    ENCODER_SIGNAL_FAULT <= f;
    PARAMETER_ERROR <= p;
    settle();
  endtask

  initial begin
    CORE_CLK = 1'b0;
    RST_N = 1'b0;
    {PSEL, PENABLE, PWRITE, ENCODER_SIGNAL_FAULT, PARAMETER_ERROR} = 5'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    ENCODER_STATUS = 4'h0;
    ctl = 32'h0;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    settle();
    chk("reset image", 64'h0000000000002400, INPUT_IMAGE);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 33'h100000000, {er, rd});
    bank_wr(6'h01, 32'h12345678);
    chk("write_done ok", 1'b1, INPUT_IMAGE[23]);
    put_ctl(32'h00000001);
    chk("read index 1", 40'h1234567801, INPUT_IMAGE[63:24]);
    apb(1'b0, `EIB_ADDR_IMG_HI, 32'h0);
    chk("apb image hi", 32'h12345678, rd);
    apb(1'b0, `EIB_ADDR_IMG_LO, 32'h0);
    chk("apb image lo", 33'h001802000, {er, rd});
    for (int i = 0; i < 2; i++) begin
      put_ctl(i ? 32'h0000003F : 32'h00000020);
      chk("rejected read", i ? 40'hBF : 40'hA0, INPUT_IMAGE[63:24]);
    end
    for (int i = 0; i < 2; i++) begin
      bank_wr(i ? 6'h20 : 6'h00, 32'h5);
      chk("write_done refused", 1'b0, INPUT_IMAGE[23]);
    end
    put_ctl(32'h00020000);
    enc.put(32'h10);
    settle();
    enc.put(32'h20);
    settle();
    chk("up", 34'h200000020, {INPUT_IMAGE[15:14], INPUT_IMAGE[63:32]});
    enc.put(32'h5);
    settle();
    chk("down", 2'b01, INPUT_IMAGE[15:14]);
    enc.put(32'h5);
    settle();
    chk("steady", 2'b00, INPUT_IMAGE[15:14]);
    enc.put(32'h12345678);
    settle();
    chk("cmp a match", 6'h27, INPUT_IMAGE[13:8]);
    enc.put(32'h12345679);
    settle();
    chk("cmp a held", 3'b110, INPUT_IMAGE[10:8]);
    put_ctl(32'h00060000);
    put_ctl(32'h00020000);
    chk("cmp a cleared", 3'b100, INPUT_IMAGE[10:8]);
    bank_wr(6'h02, 32'h1);
    put_ctl(32'h00080000);
    enc.put(32'h1);
    settle();
    chk("cmp b match", 6'h38, INPUT_IMAGE[13:8]);
    pins(4'hA, 1'b0, 1'b0);
    chk("status", 9'h141, {INPUT_IMAGE[19:16], INPUT_IMAGE[4:0]});
    bank_wr(6'h05, 32'h5);
    settle();
    chk("masked summary", 1'b0, INPUT_IMAGE[0]);
    bank_wr(6'h03, 32'h10);
    bank_wr(6'h04, 32'h0);
    pins(4'h0, 1'b1, 1'b1);
    chk("diagnostics", 13'h109E, {LINK_HALTED, INPUT_IMAGE[19:16], INPUT_IMAGE[7:0]});
    pins(4'h0, 1'b0, 1'b0);
    chk("live release", 4'h0, {LINK_HALTED, INPUT_IMAGE[7], INPUT_IMAGE[4], INPUT_IMAGE[1]});
    put_ctl(32'h01000000);
    chk("stop", 2'b11, {LINK_HALTED, INPUT_IMAGE[7]});
    test_done();
  end
endmodule // tb_top
